// ===== hdl/lpct_ctrl.sv
`timescale 1ns/1ns
module lpct_ctrl (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // configuration levels
  input wire logic fast_grade_i,
  input wire logic automotive_i,
  input wire logic [1:0] cas_latency_i,
  input wire logic auto_pre_i,
  // user request
  input wire logic req_valid_i,
  input wire lpct_pkg::lpct_req_t req_kind_i,
  input wire logic [lpct_pkg::BANK_W-1:0] req_bank_i,
  input wire logic [lpct_pkg::ROW_W-1:0] req_row_i,
  input wire logic [lpct_pkg::COL_W-1:0] req_col_i,
  input wire logic [lpct_pkg::DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic [lpct_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  // power control
  input wire logic lowpower_req_i,
  input wire logic temp_enable_i,
  output logic temp_valid_o,
  output logic freq_change_ok_o,
  output logic refresh_due_o,
  // memory pins
  output logic [lpct_pkg::CMD_W-1:0] cmd_o,
  output logic cke_o,
  output logic [lpct_pkg::BANK_W-1:0] ba_o,
  output logic [lpct_pkg::ROW_W-1:0] addr_o,
  output logic [lpct_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [lpct_pkg::DATA_W-1:0] dq_i,
  output logic [lpct_pkg::NUM_LANES-1:0] dqs_o,
  output logic [lpct_pkg::NUM_LANES-1:0] dqs_oe_o
);
  import lpct_pkg::*;

  lpct_state_t state;
  lpct_state_t next_state;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [ROW_W-1:0] open_row [NUM_BANKS];
  logic [NUM_BANKS-1:0] row_open;
  logic [NUM_BANKS-1:0] bank_ok;
  logic [NUM_BANKS-1:0] ras_ok;
  logic [NUM_BANKS-1:0] bank_load;
  logic [NUM_BANKS-1:0] ras_load;
  logic [CNT_W-1:0] bank_val;
  logic gap_load;
  logic [CNT_W-1:0] gap_val;
  logic gap_ok;
  logic stat_gap_load;
  logic stat_gap_ok;
  logic ref_ok;
  logic [CNT_W-1:0] ref_val;
  logic [TQ_CNT_W-1:0] tq_count;
  logic [5:0] rd_pipe;
  logic [1:0] wpost;
  logic hit;
  logic issue;
  logic [CNT_W-1:0] cl_cyc;
  logic [CNT_W-1:0] xp_cyc;
  lpct_req_t kind_q;

  assign cl_cyc = CNT_W'(cas_latency_i);
  assign xp_cyc = fast_grade_i ? CNT_W'(XP_FAST_CYC) : CNT_W'(XP_SLOW_CYC); // R6
  assign ref_val = automotive_i ? CNT_W'(REFI_AUTO_CYC) : CNT_W'(REFI_CYC); // R12
  assign hit = row_open[req_bank_i] && (open_row[req_bank_i] == req_row_i);

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      lpct_down_counter #(.W(CNT_W)) u_bank (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .load_i(bank_load[b]),
        .value_i(bank_val), .done_o(bank_ok[b])
      );
      // active-to-precharge guard before auto precharge
      lpct_down_counter #(.W(CNT_W)) u_ras ( // R11
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .load_i(ras_load[b]),
        .value_i(CNT_W'(RAS_CYC)), .done_o(ras_ok[b])
      );
    end
  endgenerate

  lpct_down_counter #(.W(CNT_W)) u_gap ( // R15
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .load_i(gap_load),
    .value_i(gap_val), .done_o(gap_ok)
  );
  lpct_down_counter #(.W(CNT_W)) u_stat_gap (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .load_i(stat_gap_load),
    .value_i(CNT_W'(STAT_TO_READ_CYC)), .done_o(stat_gap_ok)
  );
  lpct_down_counter #(.W(CNT_W)) u_ref (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .load_i(ref_ok && state == LPCT_IDLE),
    .value_i(ref_val), .done_o(ref_ok)
  );
  assign refresh_due_o = ref_ok;

  // input synchroniser for read data
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
    end
  end

  always_comb begin
    next_state = state;
    issue = 1'b0;
    gap_load = 1'b0;
    gap_val = '0;
    stat_gap_load = 1'b0;
    bank_load = '0;
    bank_val = '0;
    ras_load = '0;
    unique case (state)
      LPCT_IDLE: begin
        if (lowpower_req_i && gap_ok) begin
          next_state = LPCT_LOWP;
        end else if (req_valid_i && gap_ok) begin
          if (req_kind_i == LPCT_REQ_STAT) begin
            next_state = LPCT_STAT;
          end else if (req_kind_i == LPCT_REQ_REF) begin
            issue = 1'b1;
            gap_load = 1'b1;
            gap_val = CNT_W'(DAL_CYC);
          end else if (bank_ok[req_bank_i]) begin
            next_state = hit ? LPCT_RW : LPCT_ACT;
          end
        end
      end
      LPCT_ACT: begin
        ras_load[req_bank_i] = 1'b1;
        bank_load[req_bank_i] = 1'b1;
        bank_val = CNT_W'(RP_CYC);
        next_state = LPCT_RW;
      end
      LPCT_RW: begin
        if (bank_ok[req_bank_i] && (!auto_pre_i || ras_ok[req_bank_i]) // R11
            && (req_kind_i != LPCT_REQ_RD || stat_gap_ok)) begin // R1
          issue = 1'b1;
          next_state = (req_kind_i == LPCT_REQ_WR) ? LPCT_WPOST : LPCT_IDLE;
          if (auto_pre_i) begin
            bank_load[req_bank_i] = 1'b1;
            bank_val = (req_kind_i == LPCT_REQ_WR) ? CNT_W'(DAL_CYC) : CNT_W'(RP_CYC); // R10
          end else if (req_kind_i == LPCT_REQ_WR) begin
            bank_load[req_bank_i] = 1'b1;
            bank_val = CNT_W'(WR_CYC); // R5
          end
        end
      end
      LPCT_WPOST: begin
        if (wpost == 2'h0) begin
          next_state = LPCT_IDLE;
        end
      end
      LPCT_STAT: begin
        issue = 1'b1;
        gap_load = 1'b1;
        gap_val = cl_cyc + CNT_W'(1); // R1
        stat_gap_load = 1'b1; // R1
        next_state = LPCT_IDLE;
      end
      LPCT_LOWP: begin
        if (!lowpower_req_i) begin
          gap_load = 1'b1;
          gap_val = automotive_i ? CNT_W'(XSR_CYC) : xp_cyc; // R7
          next_state = LPCT_EXIT;
        end
      end
      LPCT_EXIT: begin
        if (gap_ok) begin
          next_state = LPCT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= LPCT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign req_ready_o = issue;
  assign freq_change_ok_o = (state == LPCT_LOWP); // R9

  // command pins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmd_o <= CMD_NOP;
      ba_o <= '0;
      addr_o <= '0;
      cke_o <= 1'b1;
      kind_q <= LPCT_REQ_RD;
    end else begin
      cke_o <= (next_state != LPCT_LOWP);
      ba_o <= req_bank_i;
      cmd_o <= CMD_NOP;
      if (state == LPCT_ACT) begin
        cmd_o <= CMD_ACT;
        addr_o <= req_row_i;
      end else if (state == LPCT_STAT) begin
        cmd_o <= CMD_MRS;
      end else if (issue) begin
        kind_q <= req_kind_i;
        addr_o <= ROW_W'({auto_pre_i, req_col_i});
        unique case (req_kind_i)
          LPCT_REQ_RD: cmd_o <= CMD_READ;
          LPCT_REQ_WR: cmd_o <= CMD_WRITE;
          LPCT_REQ_REF: cmd_o <= CMD_REF;
          LPCT_REQ_STAT: cmd_o <= CMD_NOP;
        endcase
      end
    end
  end

  // open-row tracking, spreads nothing but exposes hits
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      row_open <= '0;
      for (int i = 0; i < NUM_BANKS; i++) begin
        open_row[i] <= '0;
      end
    end else if (state == LPCT_ACT) begin
      row_open[req_bank_i] <= 1'b1;
      open_row[req_bank_i] <= req_row_i;
    end else if (issue && (auto_pre_i || req_kind_i == LPCT_REQ_REF)) begin
      row_open <= auto_pre_i ? (row_open & ~(NUM_BANKS'(1) << req_bank_i)) : '0; // R13
    end
  end

  // write strobes: driven low at command, toggle with data, postamble
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dqs_o <= '0;
      dqs_oe_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      wpost <= 2'h0;
    end else if (issue && req_kind_i == LPCT_REQ_WR) begin
      dqs_oe_o <= '1; // R4
      dqs_o <= '0; // R3
      dq_o <= req_wdata_i; // R14
      dq_oe_o <= 1'b1;
      wpost <= 2'h2;
    end else if (wpost != 2'h0) begin
      dqs_o <= ~dqs_o;
      wpost <= wpost - 2'h1; // R3
    end else begin
      dqs_oe_o <= '0;
      dqs_o <= '0;
      dq_oe_o <= 1'b0;
    end
  end

  // read capture after latency plus sync stages
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_pipe <= '0;
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      // pin launch, device latency and two sync stages before capture
      rd_pipe <= {rd_pipe[4:0], issue && req_kind_i == LPCT_REQ_RD};
      rdata_valid_o <= (cas_latency_i == 2'h2) ? rd_pipe[4] : rd_pipe[5]; // R8
      rdata_o <= dq_s2;
    end
  end

  // temperature sensor valid timer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tq_count <= '0;
      temp_valid_o <= 1'b0;
    end else if (!temp_enable_i) begin
      tq_count <= '0;
      temp_valid_o <= 1'b0;
    end else if (tq_count != TQ_CNT_W'(TQ_CYC)) begin
      tq_count <= tq_count + TQ_CNT_W'(1);
    end else begin
      temp_valid_o <= 1'b1; // R2
    end
  end
endmodule // lpct_ctrl

// ===== hdl/lpct_down_counter.sv
`timescale 1ns/1ns
module lpct_down_counter #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  output logic done_o
);
  logic [W-1:0] count;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end
  // no path from load to done, so a caller may load on done
  assign done_o = (count == '0);
endmodule // lpct_down_counter

// ===== hdl/lpct_pkg.sv
// How it works
// R1 - after a status register read wait CL+1 cycles before any command, and keep 2 cycles from the status access to a read.
// R2 - treat the temperature sensor output as valid only 2 ms after it was enabled.
// R3 - drive a write strobe preamble of at least a quarter clock and a postamble of 0.4 to 0.6 clock; the controller drives a one-clock postamble.
// R4 - make the strobe a valid level on or before the write command clock.
// R5 - allow 15 ns of write recovery, with at least one whole cycle in auto-precharge mode.
// R6 - after power-down exit wait 2 cycles for the fast grade and 1 for the slow grade.
// R7 - after self-refresh exit wait 112.5 ns and toggle the clock at least twice meanwhile.
// R8 - read data arrives one clock after the command for latency 2 and two clocks for latency 3.
// R9 - change the clock frequency only in clock-stop, power-down or self-refresh state.
// R10 - the auto-precharge write-to-activate delay is the sum of recovery and precharge, each rounded up to cycles.
// R11 - issue no auto-precharge access before the active-to-precharge minimum will be met.
// R12 - automotive parts halve the refresh period and the average refresh interval.
// R13 - spread accesses across rows, since hammering one row shortens device life; the controller spreads nothing and only tracks open rows for hits.
// R14 - each strobe covers one byte lane, lane n on data bits 8n+7 down to 8n.
// R15 - every nanosecond minimum becomes whole cycles rounded up and is enforced by down-counters.
package lpct_pkg;
  localparam int CLK_PS = 100000;
  localparam logic [1:0] CL_DEFAULT = 2'h3;
  localparam int STAT_TO_READ_CYC = 2;
  localparam int TQ_MS = 2;
  localparam int TQ_CYC = TQ_MS * 1000000000 / CLK_PS;
  localparam int WR_PS = 15000;
  localparam int WR_CYC_RAW = (WR_PS + CLK_PS - 1) / CLK_PS;
  localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  localparam int RP_PS = 18000;
  localparam int RP_CYC = (RP_PS + CLK_PS - 1) / CLK_PS;
  localparam int DAL_CYC = WR_CYC + RP_CYC;
  localparam int RAS_PS = 42000;
  localparam int RAS_CYC = (RAS_PS + CLK_PS - 1) / CLK_PS;
  localparam int XP_FAST_CYC = 2;
  localparam int XP_SLOW_CYC = 1;
  localparam int XSR_PS = 112500;
  localparam int XSR_CYC_RAW = (XSR_PS + CLK_PS - 1) / CLK_PS;
  localparam int XSR_MIN_TOGGLES = 2;
  localparam int XSR_CYC = (XSR_CYC_RAW < XSR_MIN_TOGGLES) ? XSR_MIN_TOGGLES : XSR_CYC_RAW;
  localparam int REFI_NS = 7800;
  localparam int REFI_CYC = REFI_NS * 1000 / CLK_PS;
  localparam int REFI_AUTO_CYC = REFI_CYC / 2;
  localparam int CNT_W = 16;
  localparam int TQ_CNT_W = 16;
  localparam int NUM_LANES = 2;
  localparam int LANE_W = 8;
  localparam int DATA_W = NUM_LANES * LANE_W;
  localparam int BANK_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int CMD_W = 3;
  localparam logic [CMD_W-1:0] CMD_NOP = 3'h7;
  localparam logic [CMD_W-1:0] CMD_ACT = 3'h3;
  localparam logic [CMD_W-1:0] CMD_READ = 3'h5;
  localparam logic [CMD_W-1:0] CMD_WRITE = 3'h4;
  localparam logic [CMD_W-1:0] CMD_PRE = 3'h2;
  localparam logic [CMD_W-1:0] CMD_REF = 3'h1;
  localparam logic [CMD_W-1:0] CMD_MRS = 3'h0;
  typedef enum logic [6:0] {
    LPCT_IDLE = 7'h01,
    LPCT_ACT = 7'h02,
    LPCT_RW = 7'h04,
    LPCT_WPOST = 7'h08,
    LPCT_LOWP = 7'h10,
    LPCT_EXIT = 7'h20,
    LPCT_STAT = 7'h40
  } lpct_state_t;
  typedef enum logic [1:0] {
    LPCT_REQ_RD = 2'h0,
    LPCT_REQ_WR = 2'h1,
    LPCT_REQ_STAT = 2'h2,
    LPCT_REQ_REF = 2'h3
  } lpct_req_t;
endpackage

// ===== verif/lpct_ctrl_monitor.sv
`timescale 1ns/1ns
module lpct_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // configuration
  input wire logic fast_grade_i,
  input wire logic automotive_i,
  input wire logic [1:0] cas_latency_i,
  input wire logic auto_pre_i,
  input wire logic temp_enable_i,
  // observed outputs
  input wire logic temp_valid_o,
  input wire logic freq_change_ok_o,
  input wire logic rdata_valid_o,
  input wire logic [lpct_pkg::CMD_W-1:0] cmd_o,
  input wire logic cke_o,
  input wire logic dq_oe_o,
  input wire logic [lpct_pkg::NUM_LANES-1:0] dqs_oe_o,
  input wire logic [lpct_pkg::NUM_LANES-1:0] dqs_o
);
  import lpct_pkg::*;
  logic [15:0] tq_cnt;
  // cycles the sensor enable has been held high
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !temp_enable_i) begin
      tq_cnt <= 16'h0;
    end else if (tq_cnt != 16'hffff) begin
      tq_cnt <= tq_cnt + 16'h1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence nop2_s;
    cmd_o == CMD_NOP ##1 cmd_o == CMD_NOP;
  endsequence
  sequence nop3_s;
    nop2_s ##1 cmd_o == CMD_NOP;
  endsequence
  sequence post_s;
    dqs_o == 2'h3 ##1 dqs_o == 2'h0;
  endsequence
  wr_post_a: assert property (cmd_o == CMD_WRITE |-> dqs_o == 2'h0 ##1 post_s)
    else $error("write strobe preamble or postamble wrong");
  stat_gap_a: assert property (
    cmd_o == CMD_MRS |=> if (cas_latency_i == 2'h3) nop3_s else nop2_s)
    else $error("command too soon after status read");
  tq_wait_a: assert property ($rose(temp_valid_o) |-> tq_cnt >= TQ_CYC - 1)
    else $error("sensor valid too early");
  wr_strobe_a: assert property (cmd_o == CMD_WRITE |-> ##[0:1] dqs_oe_o == 2'h3)
    else $error("strobe not driven at write");
  dal_gap_a: assert property (
    cmd_o == CMD_WRITE && auto_pre_i |=> (cmd_o != CMD_ACT) [*4])
    else $error("activate too soon after write");
  pd_exit_a: assert property ($rose(cke_o) |-> cmd_o == CMD_NOP)
    else $error("command at power-down exit");
  long_exit_a: assert property (
    $rose(cke_o) && (fast_grade_i || automotive_i) |-> nop2_s)
    else $error("command too soon after exit");
  freq_ok_a: assert property (freq_change_ok_o |-> !cke_o)
    else $error("frequency change allowed while running");
  lane_pair_a: assert property (dq_oe_o |-> dqs_oe_o == 2'h3)
    else $error("data driven without lane strobes");
  rd_latency_a: assert property (cmd_o == CMD_READ |-> ##[4:7] rdata_valid_o)
    else $error("read data not returned");
endmodule // lpct_monitor
bind lpct_ctrl lpct_monitor chk_u (.mclk_i, .rst_n_i, .fast_grade_i, .automotive_i,
  .cas_latency_i, .auto_pre_i, .temp_enable_i, .temp_valid_o, .freq_change_ok_o,
  .rdata_valid_o, .cmd_o, .cke_o, .dq_oe_o, .dqs_oe_o, .dqs_o);

// ===== verif/lpct_ctrl_tb_top.sv
`timescale 1ns/1ns
module lpct_ctrl_tb_top;
  import lpct_pkg::*;
  localparam int LIMIT = TQ_CYC + 5000;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fast_grade_i = 1'b1;
  logic automotive_i = 1'b0;
  logic [1:0] cas_latency_i = 2'h3;
  logic auto_pre_i = 1'b1;
  logic req_valid_i = 1'b0;
  lpct_req_t req_kind_i = LPCT_REQ_RD;
  logic [BANK_W-1:0] req_bank_i = 2'h1;
  logic [ROW_W-1:0] req_row_i = 13'h5;
  logic [COL_W-1:0] req_col_i = 10'h0;
  logic [DATA_W-1:0] req_wdata_i = 16'h0;
  logic lowpower_req_i = 1'b0;
  logic temp_enable_i = 1'b0;
  logic req_ready_o, rdata_valid_o, temp_valid_o, freq_change_ok_o, refresh_due_o;
  logic cke_o, dq_oe_o, cke_q;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_i;
  logic [CMD_W-1:0] cmd_o;
  logic [CMD_W-1:0] last_cmd = CMD_NOP;
  logic [BANK_W-1:0] ba_o;
  logic [ROW_W-1:0] addr_o;
  logic [NUM_LANES-1:0] dqs_o, dqs_oe_o;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int last_at = 0;
  int up_at = 0;
  int stat_gap, wr_gap, xp_gap;
  always #50 mclk_i = ~mclk_i;
  lpct_ctrl dut_u (.*);
  lpct_mem_model mem_u (.mclk_i, .cas_latency_i, .cmd_i(cmd_o), .ba_i(ba_o),
    .addr_i(addr_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .dqs_oe_i(dqs_oe_o), .dq_o(dq_i));
  task automatic close_out();
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog and command spacing recorder
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    cke_q <= cke_o;
    if (cke_o === 1'b1 && cke_q === 1'b0) up_at <= cyc;
    if (cmd_o !== CMD_NOP) begin
      if (last_cmd === CMD_MRS) stat_gap <= cyc - last_at;
      if (last_cmd === CMD_WRITE) wr_gap <= cyc - last_at;
      if (last_at < up_at) xp_gap <= cyc - up_at;
      last_cmd <= cmd_o;
      last_at <= cyc;
    end
    if (cyc == LIMIT) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic do_req(lpct_req_t k, logic [DATA_W-1:0] wd);
    req_kind_i <= k;
    req_wdata_i <= wd;
    req_valid_i <= 1'b1;
    do @(posedge mclk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    // let an edge pass so a following request never re-raises valid at once
    @(posedge mclk_i);
  endtask
  task automatic wait_rd();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rdata_valid_o !== 1'b1 && n < 30);
    chk("rd_done", n < 30, 1'b1);
  endtask
  task automatic t_refresh(logic auto, int exp);
    int n;
    automotive_i <= auto;
    do_reset();
    // the interval counter starts empty, so the first due comes at once
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (refresh_due_o !== 1'b1 && n < 400);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (refresh_due_o !== 1'b1 && n < 400);
    chk("refi", n >= exp - 2 && n <= exp + 2, 1'b1);
    do_req(LPCT_REQ_REF, 16'h0);
    wait (last_cmd === CMD_REF || cyc > LIMIT - 10);
    chk("ref_cmd", last_cmd, CMD_REF);
  endtask
  task automatic t_rw(logic [1:0] cl);
    logic [DATA_W-1:0] wd;
    wd = 16'ha53c ^ {14'h0, cl};
    cas_latency_i <= cl;
    req_col_i <= {8'h0, cl};
    do_req(LPCT_REQ_WR, wd);
    do_req(LPCT_REQ_RD, 16'h0);
    wait_rd();
    chk("rdata", rdata_o, wd);
    chk("dal_gap", wr_gap >= 1 + DAL_CYC, 1'b1);
    do_req(LPCT_REQ_STAT, 16'h0);
    do_req(LPCT_REQ_RD, 16'h0);
    wait_rd();
    chk("stat_gap", stat_gap >= int'(cl) + 1, 1'b1);
  endtask
  task automatic t_lp(logic fast, logic auto, int need);
    fast_grade_i <= fast;
    automotive_i <= auto;
    lowpower_req_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    chk("cke_low", cke_o, 1'b0);
    chk("freq_ok", freq_change_ok_o, 1'b1);
    lowpower_req_i <= 1'b0;
    do_req(LPCT_REQ_RD, 16'h0);
    wait_rd();
    chk("exit_gap", xp_gap >= need, 1'b1);
    chk("freq_run", freq_change_ok_o, 1'b0);
  endtask
  task automatic t_temp();
    int n;
    temp_enable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (temp_valid_o !== 1'b1 && n < TQ_CYC + 10);
    chk("tq", n >= TQ_CYC && n <= TQ_CYC + 2, 1'b1);
    temp_enable_i <= 1'b0;
  endtask
  initial begin
    t_refresh(1'b0, REFI_CYC);
    t_refresh(1'b1, REFI_AUTO_CYC);
    t_rw(2'h2);
    t_rw(2'h3);
    t_lp(1'b1, 1'b0, XP_FAST_CYC);
    t_lp(1'b0, 1'b0, XP_SLOW_CYC);
    t_lp(1'b0, 1'b1, XSR_CYC);
    t_temp();
    close_out();
  end
endmodule // lpct_ctrl_tb_top

// ===== verif/lpct_mem_model.sv
`timescale 1ns/1ns
module lpct_mem_model (
  // clock and latency
  input wire logic mclk_i,
  input wire logic [1:0] cas_latency_i,
  // command pins
  input wire logic [lpct_pkg::CMD_W-1:0] cmd_i,
  input wire logic [lpct_pkg::BANK_W-1:0] ba_i,
  input wire logic [lpct_pkg::ROW_W-1:0] addr_i,
  // data pins
  input wire logic [lpct_pkg::DATA_W-1:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic [lpct_pkg::NUM_LANES-1:0] dqs_oe_i,
  output logic [lpct_pkg::DATA_W-1:0] dq_o
);
  import lpct_pkg::*;
  logic [DATA_W-1:0] mem [0:4095];
  logic [11:0] wr_at;
  logic [11:0] rd_at;
  int rd_wait = 0;
  int hold = 0;
  initial dq_o = 16'h5a5a;
  always @(posedge mclk_i) begin
    // released bus shows the inverse, never a stale word
    if (hold > 0) begin
      hold--;
      if (hold == 0) dq_o <= #5 ~dq_o;
    end
    if (rd_wait > 0) begin
      rd_wait--;
      if (rd_wait == 0) begin
        dq_o <= #5 mem[rd_at];
        hold = 2;
      end
    end
    if (cmd_i === CMD_WRITE) wr_at = {ba_i, addr_i[COL_W-1:0]};
    if (cmd_i === CMD_READ) begin
      rd_at = {ba_i, addr_i[COL_W-1:0]};
      rd_wait = int'(cas_latency_i) - 1;
    end
    for (int n = 0; n < NUM_LANES; n++) begin
      if (dq_oe_i && dqs_oe_i[n]) mem[wr_at][8*n +: 8] = dq_i[8*n +: 8];
    end
  end
endmodule // lpct_mem_model
